// ### rtl/pcm_port.v
// Seven-pin shared port with peripheral override mux and AXI4-Lite slave
// Summary of operation
// RULE1: Direction 1 floats the pin driver; direction 0 drives the latch bit.
// RULE2: Latch register reads and writes latched values, never pin levels.
// RULE3: Direction reads return stored contents despite peripheral overrides.
// RULE4: After reset every pin is a digital input.
// RULE5: Timer oscillator enable takes pins 0 and 1, disabling digital I/O.
// RULE6: Pin 1: compare/PWM B drives when direction 0; capture B input when 1.
// RULE7: Capture B uses pin 1 unless pin-select bit is 0, then alternate pin.
// RULE8: Pin 1 can drive the external transceiver output-enable.
// RULE9: Pin 2: enhanced compare/PWM drives when direction 0; capture when 1.
// RULE10: Pin 2 carries enhanced PWM A first; optional float during shutdown.
// RULE11: Pins 4 and 5 port input reads zero while USB unit enabled.
// RULE12: Pins 4 and 5 have no direction bits; input only in port mode.
// RULE13: Internal transceiver: pins 4/5 carry USB lines, USB sets direction.
// RULE14: External transceiver: pins 4/5 are minus/plus receive inputs.
// RULE15: Pin 6 async transmit overrides port data; software sets direction. Code drives pin 6 whatever its direction bit says.
// RULE16: Pin 6 sync clock is driven out as master or taken in as slave.
// RULE17: Pin 7 feeds async receive when its direction bit is 1.
// RULE18: Pin 7 sync data driven out when sending, taken in otherwise.
// RULE19: Pin 7 carries SPI data out when its direction bit is 0.
// RULE20: Unimplemented bits read zero: port bit 3, latch/direction bits 5..3.
// RULE21: Port register reads sampled pins; writing it updates the latch.
// RULE22: One driver per pin by fixed priority; latch data lowest.
`timescale 1ns/1ps
`include "pcm_regs.vh"

module pcm_port (
  input wire CORE_CLK_IN,
  input wire ARST_N_IN,
  input wire [`PCM_ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire [2:0] S_AXI_AWPROT_IN,
  input wire S_AXI_AWVALID_IN,
  output wire S_AXI_AWREADY_OUT,
  input wire [31:0] S_AXI_WDATA_IN,
  input wire [3:0] S_AXI_WSTRB_IN,
  input wire S_AXI_WVALID_IN,
  output wire S_AXI_WREADY_OUT,
  output wire [1:0] S_AXI_BRESP_OUT,
  output wire S_AXI_BVALID_OUT,
  input wire S_AXI_BREADY_IN,
  input wire [`PCM_ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire [2:0] S_AXI_ARPROT_IN,
  input wire S_AXI_ARVALID_IN,
  output wire S_AXI_ARREADY_OUT,
  output wire [31:0] S_AXI_RDATA_OUT,
  output wire [1:0] S_AXI_RRESP_OUT,
  output wire S_AXI_RVALID_OUT,
  input wire S_AXI_RREADY_IN,
  input wire [7:0] PAD_IN,
  output wire [7:0] PAD_OUT,
  output wire [7:0] PAD_OE_N_OUT,
  input wire CAPB_DRIVE_IN,
  input wire CAPB_DATA_IN,
  input wire ALT_CAPB_PIN_IN,
  input wire ECC_DRIVE_IN,
  input wire ECC_DATA_IN,
  input wire EPWM_A_DRIVE_IN,
  input wire EPWM_A_DATA_IN,
  input wire EPWM_SHUTDOWN_IN,
  input wire XCVR_OE_DATA_IN,
  input wire USB_DRIVE_IN,
  input wire USB_MINUS_DATA_IN,
  input wire USB_PLUS_DATA_IN,
  input wire SER_TX_DATA_IN,
  input wire SER_CLOCK_DATA_IN,
  input wire SER_DATA_DRIVE_IN,
  input wire SER_DATA_DATA_IN,
  input wire SPI_DATA_IN,
  output wire TIMER_OSC_EN_OUT,
  output wire USB_UNIT_ENABLE_OUT,
  output wire EXT_XCVR_SEL_OUT,
  output wire TIMER_COUNTER_IN_OUT,
  output wire CAPB_CAPTURE_OUT,
  output wire ALT_CAPB_DRIVE_OUT,
  output wire ALT_CAPB_DATA_OUT,
  output wire ECC_CAPTURE_OUT,
  output wire USB_MINUS_RX_OUT,
  output wire USB_PLUS_RX_OUT,
  output wire SER_RX_OUT,
  output wire SER_CLOCK_RX_OUT,
  output wire SER_DATA_RX_OUT
);

  // Register file
  reg [7:0] latch_r;
  reg [7:0] dir_r;
  reg [7:0] usb_r;
  reg [7:0] cfg_r;
  reg [7:0] pin_smp_r;

  // Write channel state
  reg aw_held_r;
  reg [`PCM_ADDR_W-1:0] aw_addr_r;
  reg w_held_r;
  reg [7:0] w_data_r;
  reg w_strb0_r;
  reg bvalid_r;
  reg [1:0] bresp_r;

  // Read channel state
  reg rvalid_r;
  reg [7:0] rdata_r;
  reg [1:0] rresp_r;

  // Bus handshake terms
  wire aw_fire;
  wire w_fire;
  wire wr_go;
  wire ar_fire;

  assign S_AXI_AWREADY_OUT = ~aw_held_r & ~bvalid_r;
  assign S_AXI_WREADY_OUT = ~w_held_r & ~bvalid_r;
  assign aw_fire = S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT;
  assign w_fire = S_AXI_WVALID_IN & S_AXI_WREADY_OUT;
  assign wr_go = aw_held_r & w_held_r;
  assign S_AXI_BVALID_OUT = bvalid_r;
  assign S_AXI_BRESP_OUT = bresp_r;

  assign S_AXI_ARREADY_OUT = ~rvalid_r;
  assign ar_fire = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;
  assign S_AXI_RVALID_OUT = rvalid_r;
  assign S_AXI_RDATA_OUT = {24'h000000, rdata_r};
  assign S_AXI_RRESP_OUT = rresp_r;

  // Configuration decode
  wire usb_en;
  wire tosc_en;
  wire capb_on_pin1;
  wire ext_xcvr;
  wire epwm_tri;
  wire ser_en;
  wire ser_sync;
  wire ser_master;
  wire spi_en;

  assign usb_en = usb_r[`PCM_USB_EN_BIT];
  assign tosc_en = cfg_r[`PCM_CFG_TOSC_EN];
  assign capb_on_pin1 = cfg_r[`PCM_CFG_CAPB_SEL];
  assign ext_xcvr = cfg_r[`PCM_CFG_EXT_XCVR];
  assign epwm_tri = cfg_r[`PCM_CFG_EPWM_TRI];
  assign ser_en = cfg_r[`PCM_CFG_SER_EN];
  assign ser_sync = cfg_r[`PCM_CFG_SER_SYNC];
  assign ser_master = cfg_r[`PCM_CFG_SER_MASTER];
  assign spi_en = cfg_r[`PCM_CFG_SPI_EN];

  // Write address/data capture, taken in either order
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= {`PCM_ADDR_W{1'b0}};
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `PCM_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR_IN;
      end
      if (w_fire) begin
        w_held_r <= 1'b1;
        w_data_r <= S_AXI_WDATA_IN[7:0];
        w_strb0_r <= S_AXI_WSTRB_IN[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        if (aw_addr_r == `PCM_OFS_PIN_VALUE ||
            aw_addr_r == `PCM_OFS_LATCH ||
            aw_addr_r == `PCM_OFS_DIRECTION ||
            aw_addr_r == `PCM_OFS_USB_CONTROL ||
            aw_addr_r == `PCM_OFS_PERIPH_CFG) begin
          bresp_r <= `PCM_RESP_OKAY;
        end else begin
          bresp_r <= `PCM_RESP_SLVERR;
        end
      end else if (bvalid_r && S_AXI_BREADY_IN) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Register writes; only byte lane 0 carries data
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      latch_r <= `PCM_LATCH_RST;
      dir_r <= `PCM_DIR_RST; // [RULE4]
      usb_r <= `PCM_USB_RST;
      cfg_r <= `PCM_CFG_RST;
    end else if (wr_go && w_strb0_r) begin
      if (aw_addr_r == `PCM_OFS_PIN_VALUE) begin
        latch_r <= w_data_r & `PCM_LATCH_MASK; // [RULE21]
      end else if (aw_addr_r == `PCM_OFS_LATCH) begin
        latch_r <= w_data_r & `PCM_LATCH_MASK; // [RULE2] [RULE20]
      end else if (aw_addr_r == `PCM_OFS_DIRECTION) begin
        dir_r <= w_data_r & `PCM_DIR_MASK; // [RULE12] [RULE20]
      end else if (aw_addr_r == `PCM_OFS_USB_CONTROL) begin
        usb_r <= w_data_r & `PCM_USB_MASK;
      end else if (aw_addr_r == `PCM_OFS_PERIPH_CFG) begin
        cfg_r <= w_data_r & `PCM_CFG_MASK;
      end
    end
  end

  // Digital input view of the pins
  reg [7:0] pin_view;
  always @* begin
    pin_view = pin_smp_r & `PCM_PIN_MASK; // [RULE20]
    if (tosc_en) begin
      pin_view[1:0] = 2'h0; // [RULE5]
    end
    if (usb_en) begin
      pin_view[5:4] = 2'h0; // [RULE11]
    end
  end

  // Read channel
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= `PCM_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= `PCM_RESP_OKAY;
      if (S_AXI_ARADDR_IN == `PCM_OFS_PIN_VALUE) begin
        rdata_r <= pin_view; // [RULE21]
      end else if (S_AXI_ARADDR_IN == `PCM_OFS_LATCH) begin
        rdata_r <= latch_r; // [RULE2]
      end else if (S_AXI_ARADDR_IN == `PCM_OFS_DIRECTION) begin
        rdata_r <= dir_r; // [RULE3]
      end else if (S_AXI_ARADDR_IN == `PCM_OFS_USB_CONTROL) begin
        rdata_r <= usb_r;
      end else if (S_AXI_ARADDR_IN == `PCM_OFS_PERIPH_CFG) begin
        rdata_r <= cfg_r;
      end else begin
        rdata_r <= 8'h00;
        rresp_r <= `PCM_RESP_SLVERR;
      end
    end else if (rvalid_r && S_AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
    end
  end

  // Pin driver selection, highest priority first
  reg [7:0] drv_en;
  reg [7:0] drv_val;
  always @* begin
    drv_en = ~dir_r & `PCM_DIR_MASK; // [RULE1]
    drv_val = latch_r;
    // Pin 0
    if (tosc_en) begin
      drv_en[0] = 1'b0; // [RULE5]
    end
    // Pin 1
    if (tosc_en) begin
      drv_en[1] = 1'b0; // [RULE5]
    end else if (usb_en && ext_xcvr) begin
      drv_en[1] = 1'b1; // [RULE8] [RULE22]
      drv_val[1] = XCVR_OE_DATA_IN;
    end else if (capb_on_pin1 && CAPB_DRIVE_IN && !dir_r[1]) begin
      drv_val[1] = CAPB_DATA_IN; // [RULE6] [RULE7]
    end
    // Pin 2
    if (EPWM_A_DRIVE_IN) begin
      drv_en[2] = ~(EPWM_SHUTDOWN_IN & epwm_tri); // [RULE10] [RULE22]
      drv_val[2] = EPWM_A_DATA_IN;
    end else if (ECC_DRIVE_IN && !dir_r[2]) begin
      drv_val[2] = ECC_DATA_IN; // [RULE9]
    end
    // Pins 4 and 5
    if (usb_en && !ext_xcvr && USB_DRIVE_IN) begin
      drv_en[5:4] = 2'h3; // [RULE13]
      drv_val[5:4] = {USB_PLUS_DATA_IN, USB_MINUS_DATA_IN};
    end else begin
      drv_en[5:4] = 2'h0; // [RULE12] [RULE14]
      drv_val[5:4] = 2'h0;
    end
    // Pin 3 does not exist
    drv_en[3] = 1'b0; // [RULE20]
    drv_val[3] = 1'b0;
    // Pin 6
    // Async transmit drives whatever the direction bit says
    if (ser_en && !ser_sync) begin
      drv_en[6] = 1'b1; // [RULE15] [RULE22]
      drv_val[6] = SER_TX_DATA_IN;
    end else if (ser_en && ser_master) begin
      drv_en[6] = 1'b1; // [RULE16]
      drv_val[6] = SER_CLOCK_DATA_IN;
    end else if (ser_en) begin
      drv_en[6] = 1'b0; // [RULE16]
    end
    // Pin 7
    if (ser_en && ser_sync && SER_DATA_DRIVE_IN) begin
      drv_en[7] = 1'b1; // [RULE18] [RULE22]
      drv_val[7] = SER_DATA_DATA_IN;
    end else if (spi_en && !dir_r[7]) begin
      drv_val[7] = SPI_DATA_IN; // [RULE19]
    end
  end

  // Registered pad drive and peripheral inputs
  reg [7:0] pad_out_r;
  reg [7:0] pad_oe_n_r;
  reg tcnt_r;
  reg capb_r;
  reg alt_drv_r;
  reg alt_dat_r;
  reg ecc_r;
  reg usb_m_r;
  reg usb_p_r;
  reg rx_r;
  reg sclk_r;
  reg sdat_r;

  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pin_smp_r <= 8'h00;
      pad_out_r <= 8'h00;
      pad_oe_n_r <= 8'hFF; // [RULE4]
      tcnt_r <= 1'b0;
      capb_r <= 1'b0;
      alt_drv_r <= 1'b0;
      alt_dat_r <= 1'b0;
      ecc_r <= 1'b0;
      usb_m_r <= 1'b0;
      usb_p_r <= 1'b0;
      rx_r <= 1'b1;
      sclk_r <= 1'b0;
      sdat_r <= 1'b0;
    end else begin
      // Pads and peripheral inputs follow one edge after the mux
      pin_smp_r <= PAD_IN;
      pad_out_r <= drv_val;
      pad_oe_n_r <= ~drv_en; // [RULE1]
      tcnt_r <= dir_r[0] & ~tosc_en & pin_smp_r[0];
      if (capb_on_pin1) begin
        capb_r <= dir_r[1] & ~tosc_en & pin_smp_r[1]; // [RULE6]
      end else begin
        capb_r <= ALT_CAPB_PIN_IN; // [RULE7]
      end
      alt_drv_r <= ~capb_on_pin1 & CAPB_DRIVE_IN; // [RULE7]
      alt_dat_r <= CAPB_DATA_IN;
      ecc_r <= dir_r[2] & pin_smp_r[2]; // [RULE9]
      usb_m_r <= usb_en & pin_smp_r[4]; // [RULE13] [RULE14]
      usb_p_r <= usb_en & pin_smp_r[5];
      // Receive line idles high while pin 7 is an output
      rx_r <= dir_r[7] ? pin_smp_r[7] : 1'b1; // [RULE17]
      sclk_r <= ser_sync & ~ser_master & pin_smp_r[6]; // [RULE16]
      sdat_r <= dir_r[7] & pin_smp_r[7]; // [RULE18]
    end
  end

  assign PAD_OUT = pad_out_r;
  assign PAD_OE_N_OUT = pad_oe_n_r;
  assign TIMER_OSC_EN_OUT = tosc_en;
  assign USB_UNIT_ENABLE_OUT = usb_en;
  assign EXT_XCVR_SEL_OUT = ext_xcvr;
  assign TIMER_COUNTER_IN_OUT = tcnt_r;
  assign CAPB_CAPTURE_OUT = capb_r;
  assign ALT_CAPB_DRIVE_OUT = alt_drv_r;
  assign ALT_CAPB_DATA_OUT = alt_dat_r;
  assign ECC_CAPTURE_OUT = ecc_r;
  assign USB_MINUS_RX_OUT = usb_m_r;
  assign USB_PLUS_RX_OUT = usb_p_r;
  assign SER_RX_OUT = rx_r;
  assign SER_CLOCK_RX_OUT = sclk_r;
  assign SER_DATA_RX_OUT = sdat_r;

endmodule

// ### rtl/pcm_regs.vh
// Register map, field positions and reset values of the port block
`ifndef PCM_REGS_VH
`define PCM_REGS_VH

`define PCM_ADDR_W 5
`define PCM_OFS_PIN_VALUE 5'h00
`define PCM_OFS_LATCH 5'h04
`define PCM_OFS_DIRECTION 5'h08
`define PCM_OFS_USB_CONTROL 5'h0C
`define PCM_OFS_PERIPH_CFG 5'h10

`define PCM_PIN_MASK 8'hF7
`define PCM_LATCH_MASK 8'hC7
`define PCM_DIR_MASK 8'hC7
`define PCM_USB_MASK 8'h7E
`define PCM_CFG_MASK 8'hFF

`define PCM_LATCH_RST 8'h00
`define PCM_DIR_RST 8'hC7
`define PCM_USB_RST 8'h00
`define PCM_CFG_RST 8'h02

`define PCM_USB_EN_BIT 3

`define PCM_CFG_TOSC_EN 0
`define PCM_CFG_CAPB_SEL 1
`define PCM_CFG_EXT_XCVR 2
`define PCM_CFG_EPWM_TRI 3
`define PCM_CFG_SER_EN 4
`define PCM_CFG_SER_SYNC 5
`define PCM_CFG_SER_MASTER 6
`define PCM_CFG_SPI_EN 7

`define PCM_RESP_OKAY 2'h0
`define PCM_RESP_SLVERR 2'h2

`endif

// ### verification/pcm_port_assertions.sv
// Checker of pad muxing at the ports of the port block
`timescale 1ns/1ps
module pcm_port_chk (
  input wire CORE_CLK_IN,
  input wire ARST_N_IN,
  input wire [7:0] PAD_OUT,
  input wire [7:0] PAD_OE_N_OUT,
  input wire EPWM_A_DRIVE_IN,
  input wire EPWM_A_DATA_IN,
  input wire EPWM_SHUTDOWN_IN,
  input wire USB_DRIVE_IN,
  input wire USB_MINUS_DATA_IN,
  input wire USB_PLUS_DATA_IN,
  input wire TIMER_OSC_EN_OUT,
  input wire USB_UNIT_ENABLE_OUT,
  input wire EXT_XCVR_SEL_OUT,
  input wire TIMER_COUNTER_IN_OUT,
  input wire USB_MINUS_RX_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  pin3_float_a: assert property (PAD_OE_N_OUT[3])
    else $error("pin 3 driven");
  osc_pads_a: assert property (
    TIMER_OSC_EN_OUT |=> &PAD_OE_N_OUT[1:0])
    else $error("pins 0 1 driven with oscillator on");
  osc_count_a: assert property (
    TIMER_OSC_EN_OUT |=> !TIMER_COUNTER_IN_OUT)
    else $error("counter input live with oscillator on");
  port_in_only_a: assert property (!USB_UNIT_ENABLE_OUT |=>
    &PAD_OE_N_OUT[5:4]) else $error("pins 4 5 driven in port mode");
  ext_rx_a: assert property (
    EXT_XCVR_SEL_OUT |=> &PAD_OE_N_OUT[5:4])
    else $error("pins 4 5 driven with external transceiver");
  usb_drive_a: assert property (
    USB_UNIT_ENABLE_OUT && !EXT_XCVR_SEL_OUT &&
    USB_DRIVE_IN |=> PAD_OE_N_OUT[5:4] == 2'h0 && PAD_OUT[5:4] ==
    {$past(USB_PLUS_DATA_IN), $past(USB_MINUS_DATA_IN)})
    else $error("usb lines not driven");
  pwm_a_first_a: assert property (
    EPWM_A_DRIVE_IN && !EPWM_SHUTDOWN_IN |=>
    !PAD_OE_N_OUT[2] && PAD_OUT[2] == $past(EPWM_A_DATA_IN))
    else $error("pwm channel a lost pin 2");
  usb_rx_off_a: assert property (
    !USB_UNIT_ENABLE_OUT |=> !USB_MINUS_RX_OUT)
    else $error("usb receive live while disabled");
  cover property (USB_UNIT_ENABLE_OUT && USB_DRIVE_IN && !EXT_XCVR_SEL_OUT);
  cover property (EPWM_A_DRIVE_IN && !EPWM_SHUTDOWN_IN);
  cover property (TIMER_OSC_EN_OUT);
endmodule
bind pcm_port pcm_port_chk u_chk (.CORE_CLK_IN(CORE_CLK_IN),
  .ARST_N_IN(ARST_N_IN), .PAD_OUT(PAD_OUT), .PAD_OE_N_OUT(PAD_OE_N_OUT),
  .EPWM_A_DRIVE_IN(EPWM_A_DRIVE_IN), .EPWM_A_DATA_IN(EPWM_A_DATA_IN),
  .EPWM_SHUTDOWN_IN(EPWM_SHUTDOWN_IN), .USB_DRIVE_IN(USB_DRIVE_IN),
  .USB_MINUS_DATA_IN(USB_MINUS_DATA_IN), .USB_PLUS_DATA_IN(USB_PLUS_DATA_IN),
  .TIMER_OSC_EN_OUT(TIMER_OSC_EN_OUT),
  .USB_UNIT_ENABLE_OUT(USB_UNIT_ENABLE_OUT),
  .EXT_XCVR_SEL_OUT(EXT_XCVR_SEL_OUT),
  .TIMER_COUNTER_IN_OUT(TIMER_COUNTER_IN_OUT),
  .USB_MINUS_RX_OUT(USB_MINUS_RX_OUT));

// ### verification/pcm_pad_model.sv
// Pad model: released pins follow an outside level
`timescale 1ns/1ps
module pcm_pad_model (
  input wire [7:0] pad_out_in,
  input wire [7:0] pad_oe_n_in,
  input wire [7:0] ext_level_in,
  output wire [7:0] pad_level_out
);
  assign pad_level_out = (pad_out_in & ~pad_oe_n_in) |
    (ext_level_in & pad_oe_n_in);
endmodule

// ### verification/testbench.sv
// Self-checking bench of the port block
`timescale 1ns/1ps
`include "pcm_regs.vh"
module testbench;
  reg clk = 1'h0;
  reg rst_n = 1'h0;
  reg [4:0] awaddr = 5'h00;
  reg [4:0] araddr = 5'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  reg arvalid = 1'h0, rready = 1'h0;
  reg [7:0] ext = 8'h00;
  reg [16:0] pv = 17'h0;
  reg ha, hw, hb, hr;
  wire awready, wready, bvalid, arready, rvalid, usb_rx;
  wire capb_cap, alt_drv, alt_dat, ecc_cap, usb_p, ser_rx, sclk_rx, sdat_rx;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pad_in, pad_out, oe_n;
  integer mismatches = 0, check_count = 0, cyc = 0, i;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [1:0] exp_b[$];
  logic [1:0] b;
  reg [31:0] cfgs = 32'hF2090400;
  always #2 clk = ~clk;
  pcm_pad_model pads (.pad_out_in(pad_out), .pad_oe_n_in(oe_n),
    .ext_level_in(ext), .pad_level_out(pad_in));
  pcm_port dut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWPROT_IN(3'h0),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARPROT_IN(3'h0), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .PAD_IN(pad_in), .PAD_OUT(pad_out),
    .PAD_OE_N_OUT(oe_n), .CAPB_DRIVE_IN(pv[0]), .CAPB_DATA_IN(pv[1]),
    .ALT_CAPB_PIN_IN(pv[2]), .ECC_DRIVE_IN(pv[3]), .ECC_DATA_IN(pv[4]),
    .EPWM_A_DRIVE_IN(pv[5]), .EPWM_A_DATA_IN(pv[6]),
    .EPWM_SHUTDOWN_IN(pv[7]), .XCVR_OE_DATA_IN(pv[8]),
    .USB_DRIVE_IN(pv[9]), .USB_MINUS_DATA_IN(pv[10]),
    .USB_PLUS_DATA_IN(pv[11]), .SER_TX_DATA_IN(pv[12]),
    .SER_CLOCK_DATA_IN(pv[13]), .SER_DATA_DRIVE_IN(pv[14]),
    .SER_DATA_DATA_IN(pv[15]), .SPI_DATA_IN(pv[16]),
    .TIMER_OSC_EN_OUT(), .USB_UNIT_ENABLE_OUT(), .EXT_XCVR_SEL_OUT(),
    .TIMER_COUNTER_IN_OUT(), .CAPB_CAPTURE_OUT(capb_cap),
    .ALT_CAPB_DRIVE_OUT(alt_drv), .ALT_CAPB_DATA_OUT(alt_dat),
    .ECC_CAPTURE_OUT(ecc_cap), .USB_MINUS_RX_OUT(usb_rx),
    .USB_PLUS_RX_OUT(usb_p), .SER_RX_OUT(ser_rx),
    .SER_CLOCK_RX_OUT(sclk_rx), .SER_DATA_RX_OUT(sdat_rx));
  task chk(input string n, input logic [33:0] s, input logic [33:0] x);
    begin
      check_count = check_count + 1;
      if (s !== x) begin
        mismatches = mismatches + 1;
        $display("unexpected %s expected %h seen %h", n, x, s);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Handshakes judged mid-cycle, released after the taking edge
  task wr(input [4:0] a, input [7:0] d);
    begin
      exp_b.push_back((a == `PCM_OFS_PIN_VALUE || a == `PCM_OFS_LATCH ||
        a == `PCM_OFS_DIRECTION || a == `PCM_OFS_USB_CONTROL ||
        a == `PCM_OFS_PERIPH_CFG) ? `PCM_RESP_OKAY : `PCM_RESP_SLVERR);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      hb = 1'h0;
      while (!hb) begin
        @(negedge clk);
        ha = awvalid & awready;
        hw = wvalid & wready;
        hb = bready & bvalid;
        @(posedge clk);
        if (ha) awvalid <= 1'h0;
        if (hw) wvalid <= 1'h0;
        if (hb) bready <= 1'h0;
      end
    end
  endtask
  task rd(input [4:0] a, input [1:0] r, input [7:0] d);
    begin
      exp_q.push_back({r, 24'h0, d});
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      hr = 1'h0;
      while (!hr) begin
        @(negedge clk);
        ha = arvalid & arready;
        hr = rready & rvalid;
        @(posedge clk);
        if (ha) arvalid <= 1'h0;
        if (hr) rready <= 1'h0;
      end
    end
  endtask
  always @(negedge clk) begin
    if (rvalid & rready) begin
      e = exp_q.pop_front();
      chk("read", {rresp, rdata}, e);
    end
    if (bvalid & bready) begin
      b = exp_b.pop_front();
      chk("bresp", bresp, b);
    end
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      final_report;
    end
  end
  initial begin
    void'($urandom(32'hED3CAA6C));
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    ext <= 8'($urandom);
    chk("oe_n", oe_n, 8'hFF);
    rd(`PCM_OFS_DIRECTION, 2'h0, 8'hC7);
    rd(`PCM_OFS_LATCH, 2'h0, 8'h00);
    rd(5'h14, `PCM_RESP_SLVERR, 8'h00);
    wr(`PCM_OFS_LATCH, 8'hFF);
    rd(`PCM_OFS_LATCH, 2'h0, 8'hC7);
    wr(`PCM_OFS_DIRECTION, 8'h00);
    rd(`PCM_OFS_DIRECTION, 2'h0, 8'h00);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("oe_n", oe_n, 8'h38);
    chk("pad", pad_out & 8'hC7, 8'hC7);
    rd(`PCM_OFS_PIN_VALUE, 2'h0, 8'hC7 | ext & 8'h30);
    wr(`PCM_OFS_PIN_VALUE, 8'h00);
    rd(`PCM_OFS_LATCH, 2'h0, 8'h00);
    wr(`PCM_OFS_DIRECTION, 8'hFF);
    for (i = 0; i < 4; i = i + 1) begin
      ext <= 8'($urandom);
      repeat (3) @(posedge clk);
      rd(`PCM_OFS_PIN_VALUE, 2'h0, ext & 8'hF7);
    end
    rd(`PCM_OFS_LATCH, 2'h0, 8'h00);
    wr(`PCM_OFS_USB_CONTROL, 8'h08);
    rd(`PCM_OFS_USB_CONTROL, 2'h0, 8'h08);
    repeat (3) @(posedge clk);
    rd(`PCM_OFS_PIN_VALUE, 2'h0, ext & 8'hC7);
    chk("usb_rx", usb_rx, ext[4]);
    wr(`PCM_OFS_PERIPH_CFG, 8'h83);
    wr(`PCM_OFS_DIRECTION, 8'h00);
    pv[16] <= 1'h1;
    repeat (3) @(posedge clk);
    chk("oe_n", oe_n[1:0], 2'h3);
    chk("spi", {oe_n[7], pad_out[7]}, 2'h1);
    rd(`PCM_OFS_PIN_VALUE, 2'h0, 8'h80);
    rd(`PCM_OFS_DIRECTION, 2'h0, 8'h00);
    chk("ser_rx", ser_rx, 1'h1);
    chk("ecc_cap", ecc_cap, 1'h0);
    // Unmapped write answers an error and changes nothing
    wr(5'h14, 8'h55);
    rd(`PCM_OFS_PERIPH_CFG, 2'h0, 8'h83);
    // Sync slave serial, all pins released
    wr(`PCM_OFS_DIRECTION, 8'hFF);
    wr(`PCM_OFS_PERIPH_CFG, 8'h32);
    pv <= 17'h0;
    ext <= 8'($urandom);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("oe_n", oe_n, 8'hFF);
    chk("capb_cap", capb_cap, ext[1]);
    chk("ecc_cap", ecc_cap, ext[2]);
    chk("usb_p", usb_p, ext[5]);
    chk("sclk_rx", sclk_rx, ext[6]);
    chk("sdat_rx", sdat_rx, ext[7]);
    chk("ser_rx", ser_rx, ext[7]);
    chk("alt_drv", alt_drv, 1'h0);
    // External transceiver, capture B on the alternate pin
    wr(`PCM_OFS_PERIPH_CFG, 8'h04);
    pv <= 17'h00307;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pin1", {oe_n[1], pad_out[1]}, 2'h1);
    chk("oe_n", oe_n[5:4], 2'h3);
    chk("usb_p", usb_p, ext[5]);
    chk("capb_cap", capb_cap, 1'h1);
    chk("alt", {alt_drv, alt_dat}, 2'h3);
    // Async transmit and PWM A over released pins, then shutdown
    wr(`PCM_OFS_PERIPH_CFG, 8'h18);
    pv <= 17'h01068;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pin6", {oe_n[6], pad_out[6]}, 2'h1);
    chk("pin2", {oe_n[2], pad_out[2]}, 2'h1);
    @(posedge clk);
    pv[7] <= 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("pin2", oe_n[2], 1'h1);
    // Sync master: clock on pin 6, data on pin 7
    wr(`PCM_OFS_PERIPH_CFG, 8'h70);
    pv <= 17'h06000;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pin76", {oe_n[7:6], pad_out[7:6]}, 4'h1);
    wr(`PCM_OFS_DIRECTION, 8'h00);
    // Random peripheral traffic under several mux setups
    for (i = 0; i < 4; i = i + 1) begin
      wr(`PCM_OFS_PERIPH_CFG, cfgs[8 * i +: 8]);
      repeat (100) begin
        @(posedge clk);
        pv <= 17'($urandom);
        ext <= 8'($urandom);
      end
    end
    final_report;
  end
endmodule
